// file: design/sreu_consts.svh
`ifndef SREU_CONSTS_SVH
`define SREU_CONSTS_SVH
// ****************************************************************
// Register map (byte addresses, one word each)
// ****************************************************************
`define SREU_ADR_CTRL     8'h00
`define SREU_ADR_TRIG     8'h04
`define SREU_ADR_STATUS   8'h08
`define SREU_ADR_CLEAR    8'h0C
`define SREU_ADR_ENABLE   8'h10
`define SREU_ADR_LAST     8'h14
`define SREU_ADR_RXCNT    8'h18
// ****************************************************************
// Fields and reset values
// ****************************************************************
`define SREU_CTRL_ENC_LSB  0
`define SREU_CTRL_ENC_MSB  4
`define SREU_CTRL_FLOW_LSB 8
`define SREU_CTRL_FLOW_MSB 9
`define SREU_ST_WORD       0
`define SREU_ST_COUNT      1
`define SREU_ST_HEXERR     2
`define SREU_ST_W          3
`define SREU_RST_TRIG      32'h0000_0000
`define SREU_RST_EN        3'h0
// ****************************************************************
// Byte codes
// ****************************************************************
`define SREU_CMD_MAX   8'h07
`define SREU_TEXT_MIN  8'h20
`define SREU_CTRL_MAX  8'h1F
`define SREU_HIGH_MIN  8'h80
`define SREU_ESC_CHAR  8'h5C
`define SREU_XON       8'h11
`define SREU_XOFF      8'h13
`endif

// file: design/sreu_pkg.sv
package sreu_pkg;
  // Encode settings in register code order, starting at zero
  typedef enum logic [4:0] {
    ENC_ASCII_ESC, ENC_ASCII_TEXT, ENC_ASCII_RAW, ENC_UNI_HEX,
    ENC_UNI_TEXT, ENC_UNI_RAW, ENC_UTF8_TEXT, ENC_UTF8_RAW_A,
    ENC_UTF8_RAW_B, ENC_BYTE_BE, ENC_BYTE_LE, ENC_HALF_BE,
    ENC_HALF_LE, ENC_WORD_BE, ENC_WORD_LE, ENC_HEX_HALF_BE,
    ENC_HEX_HALF_LE, ENC_HEX_WORD_BE, ENC_HEX_WORD_LE
  } sreu_enc_t;
  typedef enum logic [1:0] {FLOW_NONE, FLOW_HW, FLOW_SW} sreu_flow_t;
  typedef enum logic [2:0] {
    KIND_NONE, KIND_CMD, KIND_CHAR, KIND_RAW, KIND_ESC, KIND_WORD
  } sreu_kind_t;
  typedef struct packed {
    sreu_kind_t  kind;
    logic [2:0]  len;
    logic [31:0] data;
  } sreu_out_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } sreu_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } sreu_wb_rsp_t;
endpackage

// file: design/sreu_top.sv
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "sreu_consts.svh"
module sreu_top #(
  parameter int CNT_W = 24
) (
  input  wire logic                  clk_i,       // 20 MHz clock
  input  wire logic                  rst_i,       // Sync reset, high
  input  wire sreu_pkg::sreu_wb_req_t wb_i,       // Wishbone request
  output sreu_pkg::sreu_wb_rsp_t     wb_o,        // Wishbone answer
  input  wire logic                  rx_valid_i,  // Received byte strobe
  input  wire logic [7:0]            rx_byte_i,   // Received byte
  input  wire logic                  hold_i,      // Receiver wants pause
  input  wire logic                  cts_i,       // Host clear to send
  output logic                       out_valid_o, // Decoded item strobe
  output sreu_pkg::sreu_out_t        out_o,       // Decoded item
  output logic                       rts_o,       // Request to send
  output logic                       tx_ok_o,     // Transmit permitted
  output logic                       tx_req_o,    // Send a flow char
  output logic [7:0]                 tx_char_o,   // Flow char to send
  output logic                       irq_o        // Level interrupt
);
  import sreu_pkg::*;

  if (CNT_W < 1 || CNT_W > 32) begin : g_chk
    $error("sreu_top: CNT_W must be 1 to 32");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      r = {1'b1, c[3:0]};
    end else if ((c >= 8'h41 && c <= 8'h46) ||
                 (c >= 8'h61 && c <= 8'h66)) begin
      r = {1'b1, c[3:0] + 4'h9};
    end
    return r;
  endfunction

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    logic [7:0] r;
    r = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    return r;
  endfunction

  function automatic logic [31:0] lanes(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  sreu_enc_t              enc_q;
  sreu_flow_t             flow_q;
  logic [CNT_W-1:0]       trig_q;
  logic [CNT_W-1:0]       rxcnt_q;
  logic [`SREU_ST_W-1:0]  sts_q;
  logic [`SREU_ST_W-1:0]  en_q;
  logic [31:0]            last_q;
  logic [31:0]            acc_q;
  logic [2:0]             bcnt_q;
  logic                   pair_ph_q;
  logic [3:0]             pair_hi_q;
  logic                   ack_q;
  logic [31:0]            rdat_q;
  logic                   hold_q;
  logic                   host_xoff_q;

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  wire        bus_req  = wb_i.cyc & wb_i.stb & ~ack_q;
  wire        bus_wr   = bus_req & wb_i.we;
  wire [7:0]  adr_w    = {wb_i.adr[7:2], 2'b00};
  wire        hit_ctrl = adr_w == `SREU_ADR_CTRL;
  wire        hit_trig = adr_w == `SREU_ADR_TRIG;
  wire        hit_sts  = adr_w == `SREU_ADR_STATUS;
  wire        hit_en   = adr_w == `SREU_ADR_ENABLE;
  wire        hit_last = adr_w == `SREU_ADR_LAST;
  wire        hit_rxc  = adr_w == `SREU_ADR_RXCNT;
  wire        hit_clr  = adr_w == `SREU_ADR_CLEAR;
  wire        wr_enc   = bus_wr & hit_ctrl & wb_i.sel[0];
  wire        wr_flow  = bus_wr & hit_ctrl & wb_i.sel[1];
  wire        wr_trig  = bus_wr & hit_trig;
  wire        wr_en    = bus_wr & hit_en & wb_i.sel[0];
  wire [`SREU_ST_W-1:0] clr_w =
    (bus_wr & hit_clr & wb_i.sel[0]) ? wb_i.dat[`SREU_ST_W-1:0]
                                     : {`SREU_ST_W{1'b0}};
  wire sreu_enc_t new_enc =
    sreu_enc_t'(wb_i.dat[`SREU_CTRL_ENC_MSB:`SREU_CTRL_ENC_LSB]);
  wire        enc_chg  = wr_enc & (new_enc != enc_q);
  wire [31:0] trig_w   = lanes(32'(trig_q),
                               wb_i.dat, wb_i.sel);

  wire [31:0] ctrl_rd = {22'h0, flow_q, 3'h0, enc_q};
  wire [31:0] rd_w =
    hit_ctrl ? ctrl_rd :
    hit_trig ? 32'(trig_q) :
    hit_sts  ? {{(32-`SREU_ST_W){1'b0}}, sts_q} :
    hit_en   ? {{(32-`SREU_ST_W){1'b0}}, en_q} :
    hit_last ? last_q :
    hit_rxc  ? 32'(rxcnt_q) : 32'h0000_0000;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire m_text  = enc_q == ENC_ASCII_TEXT || enc_q == ENC_UNI_TEXT ||
                 enc_q == ENC_UTF8_TEXT;
  wire m_raw   = enc_q == ENC_ASCII_RAW || enc_q == ENC_UNI_RAW ||
                 enc_q == ENC_UTF8_RAW_A || enc_q == ENC_UTF8_RAW_B ||
                 enc_q == ENC_BYTE_BE || enc_q == ENC_BYTE_LE;
  wire m_hex   = enc_q == ENC_UNI_HEX || enc_q == ENC_HEX_HALF_BE ||
                 enc_q == ENC_HEX_HALF_LE || enc_q == ENC_HEX_WORD_BE ||
                 enc_q == ENC_HEX_WORD_LE;
  wire m_bin   = enc_q == ENC_HALF_BE || enc_q == ENC_HALF_LE ||
                 enc_q == ENC_WORD_BE || enc_q == ENC_WORD_LE;
  wire m_four  = enc_q == ENC_WORD_BE || enc_q == ENC_WORD_LE ||
                 enc_q == ENC_HEX_WORD_BE || enc_q == ENC_HEX_WORD_LE;
  wire m_le    = enc_q == ENC_HALF_LE || enc_q == ENC_WORD_LE ||
                 enc_q == ENC_HEX_HALF_LE || enc_q == ENC_HEX_WORD_LE;
  wire m_esc   = ~(m_text | m_raw | m_hex | m_bin);

  // In software flow the host's own XON/XOFF bytes are consumed here
  wire flow_chr = flow_q == FLOW_SW &&
                  (rx_byte_i == `SREU_XON || rx_byte_i == `SREU_XOFF);
  wire rx_take  = rx_valid_i & ~flow_chr;

  // ****************************************************************
  // Hex pairing and word assembly
  // ****************************************************************
  wire [4:0] hv      = hex_val(rx_byte_i);
  wire       hex_bad = rx_take & m_hex & ~hv[4];
  wire       byte_rdy = (rx_take & m_bin) |
                        (rx_take & m_hex & hv[4] & pair_ph_q);
  wire [7:0] asm_b   = m_hex ? {pair_hi_q, hv[3:0]} : rx_byte_i;
  wire [2:0] need    = m_four ? 3'd4 : 3'd2;
  wire [31:0] acc_nx = m_le ? {asm_b, acc_q[31:8]}
                            : {acc_q[23:0], asm_b};
  wire       word_done = byte_rdy && (bcnt_q + 3'd1 == need);
  wire [31:0] word_w =
    m_four ? acc_nx :
    m_le   ? {16'h0000, acc_nx[31:16]} : {16'h0000, acc_nx[15:0]};

  // ****************************************************************
  // Byte count trigger
  // ****************************************************************
  wire [CNT_W-1:0] rxcnt_nx = rxcnt_q + CNT_W'(1);
  wire cnt_hit = rx_take && trig_q != '0 && rxcnt_nx == trig_q;

  // ****************************************************************
  // Per-byte classification
  // ****************************************************************
  sreu_out_t out_d;
  logic      out_vd;
  always_comb begin
    out_d  = '{kind: KIND_NONE, len: 3'd0, data: 32'h0000_0000};
    out_vd = 1'b0;
    if (m_bin | m_hex) begin
      out_vd = word_done & ~enc_chg;
      out_d  = '{kind: KIND_WORD, len: need, data: word_w};
    end else if (rx_take) begin
      out_vd = 1'b1;
      out_d  = '{kind: KIND_RAW, len: 3'd1,
                 data: {24'h00_0000, rx_byte_i}};
      if (m_text && rx_byte_i <= `SREU_CMD_MAX) begin
        out_d.kind = KIND_CMD;
      end else if (m_text && rx_byte_i >= `SREU_TEXT_MIN) begin
        out_d.kind = KIND_CHAR;
      end else if (m_esc && (rx_byte_i <= `SREU_CTRL_MAX ||
                             rx_byte_i >= `SREU_HIGH_MIN)) begin
        out_d = '{kind: KIND_ESC, len: 3'd3,
                  data: {8'h00, `SREU_ESC_CHAR, hex_chr(rx_byte_i[7:4]),
                         hex_chr(rx_byte_i[3:0])}};
      end else if (m_esc) begin
        out_d.kind = KIND_CHAR;
      end
      // Raw settings keep KIND_RAW
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enc_q  <= ENC_ASCII_ESC;
      flow_q <= FLOW_NONE;
      trig_q <= CNT_W'(`SREU_RST_TRIG);
      en_q   <= `SREU_RST_EN;
    end else begin
      if (wr_enc) begin
        enc_q <= new_enc;
      end
      if (wr_flow) begin
        flow_q <= sreu_flow_t'(wb_i.dat[`SREU_CTRL_FLOW_MSB:
                                        `SREU_CTRL_FLOW_LSB]);
      end
      if (wr_trig) begin
        trig_q <= trig_w[CNT_W-1:0];
      end
      if (wr_en) begin
        en_q <= wb_i.dat[`SREU_ST_W-1:0];
      end
    end
  end

  // Events win over a clear in the same cycle
  wire [`SREU_ST_W-1:0] ev_w = {hex_bad, cnt_hit, word_done & ~enc_chg};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_q <= '0;
      irq_o <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~clr_w) | ev_w;
      irq_o <= |(sts_q & en_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || enc_chg || hex_bad) begin
      acc_q     <= 32'h0000_0000;
      bcnt_q    <= 3'd0;
      pair_ph_q <= 1'b0;
      pair_hi_q <= 4'h0;
    end else begin
      if (rx_take && m_hex) begin
        pair_ph_q <= ~pair_ph_q;
        pair_hi_q <= hv[3:0];
      end
      if (byte_rdy) begin
        acc_q  <= word_done ? 32'h0000_0000 : acc_nx;
        bcnt_q <= word_done ? 3'd0 : bcnt_q + 3'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wr_trig || enc_chg) begin
      rxcnt_q <= '0;
    end else if (rx_take) begin
      rxcnt_q <= cnt_hit ? '0 : rxcnt_nx;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_o       <= '{kind: KIND_NONE, len: 3'd0, data: 32'h0000_0000};
      last_q      <= 32'h0000_0000;
    end else begin
      out_valid_o <= out_vd;
      if (out_vd) begin
        out_o  <= out_d;
        last_q <= out_d.data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= bus_req;
      rdat_q <= bus_req ? rd_w : 32'h0000_0000;
    end
  end
  assign wb_o = '{ack: ack_q, dat: rdat_q};

  // ****************************************************************
  // Flow control
  // ****************************************************************
  wire hold_rise = hold_i & ~hold_q;
  wire hold_fall = ~hold_i & hold_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q      <= 1'b0;
      host_xoff_q <= 1'b0;
      rts_o       <= 1'b1;
      tx_ok_o     <= 1'b1;
      tx_req_o    <= 1'b0;
      tx_char_o   <= 8'h00;
    end else begin
      hold_q  <= hold_i;
      rts_o   <= (flow_q == FLOW_HW) ? ~hold_i : 1'b1;
      tx_ok_o <= (flow_q == FLOW_HW) ? cts_i :
                 (flow_q == FLOW_SW) ? ~host_xoff_q : 1'b1;
      if (flow_q != FLOW_SW) begin
        host_xoff_q <= 1'b0;
      end else if (rx_valid_i && flow_chr) begin
        host_xoff_q <= rx_byte_i == `SREU_XOFF;
      end
      tx_req_o <= (flow_q == FLOW_SW) & (hold_rise | hold_fall);
      if ((flow_q == FLOW_SW) && (hold_rise || hold_fall)) begin
        tx_char_o <= hold_rise ? `SREU_XOFF : `SREU_XON;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_last_half_byte;
    byte_rdy && !m_four && bcnt_q == 3'd1 && !enc_chg;
  endsequence
  sequence s_word_out(int n);
    out_valid_o && out_o.kind == KIND_WORD && out_o.len == n;
  endsequence

  a_half_word_out: assert property (
    s_last_half_byte |=> s_word_out(2) ##0 sts_q[`SREU_ST_WORD])
    else $error("half word not emitted after two bytes");
  a_word_out: assert property (
    byte_rdy && m_four && bcnt_q == 3'd3 && !enc_chg |=> s_word_out(4))
    else $error("word not emitted after four bytes");
  a_cmd_class: assert property (
    rx_take && m_text && rx_byte_i <= `SREU_CMD_MAX
    |=> out_valid_o && out_o.kind == KIND_CMD)
    else $error("low code not classed as command");
  a_raw_pass: assert property (
    rx_take && m_raw |=> out_valid_o && out_o.kind == KIND_RAW &&
    out_o.data[7:0] == $past(rx_byte_i))
    else $error("raw byte not passed through");
  a_esc_conv: assert property (
    rx_take && m_esc && rx_byte_i >= `SREU_HIGH_MIN
    |=> out_o.kind == KIND_ESC && out_o.len == 3'd3 &&
    out_o.data[23:16] == `SREU_ESC_CHAR)
    else $error("high code not escaped");
  a_mode_restart: assert property (
    enc_chg |=> bcnt_q == 3'd0 && !pair_ph_q)
    else $error("partial word kept over mode change");
  a_count_hit: assert property (
    cnt_hit |=> sts_q[`SREU_ST_COUNT] && rxcnt_q == '0)
    else $error("byte count event missed");
  a_rts_hold: assert property (
    flow_q == FLOW_HW && hold_i && $stable(flow_q) |=> !rts_o)
    else $error("rts not dropped on hold");
  a_xoff_send: assert property (
    flow_q == FLOW_SW && hold_rise |=> tx_req_o ##0
    tx_char_o == `SREU_XOFF ##1 !tx_req_o)
    else $error("xoff not sent on hold");
  a_hex_pair: assert property (
    rx_take && m_hex && hv[4] && !enc_chg |=> pair_ph_q != $past(pair_ph_q))
    else $error("hex nibble phase did not advance");
endmodule

// file: test/sreu_host_model.sv
`timescale 1ns/10ps
`include "sreu_consts.svh"
module sreu_host_model (
  input  wire logic       clk_i,     // Bench clock
  input  wire logic       rts_i,     // Device request to send
  input  wire logic       tx_req_i,  // Device flow char strobe
  input  wire logic [7:0] tx_char_i, // Device flow char
  output logic            valid_o,   // Byte strobe to device
  output logic [7:0]      byte_o     // Byte to device
);
  logic paused_q = 1'b0;

  initial begin
    valid_o = 1'b0;
    byte_o  = 8'h00;
  end

  // ****************************************************************
  // Pause on the device's XOFF until its XON
  // ****************************************************************
  always @(posedge clk_i) begin
    if (tx_req_i && tx_char_i == `SREU_XOFF) paused_q <= 1'b1;
    if (tx_req_i && tx_char_i == `SREU_XON) paused_q <= 1'b0;
  end

  // Waits up to 200 cycles while the device holds us off; a slow host adds idle cycles
  task automatic send(input logic [7:0] b, input int gap);
    int i;
    for (i = 0; i < 200; i++) begin
      if (rts_i === 1'b1 && !paused_q) break;
      @(posedge clk_i);
    end
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    valid_o <= 1'b1;
    byte_o  <= b;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Idle line shows the inverse so a stale byte is never mistaken
    byte_o  <= ~b;
  endtask
endmodule

// file: test/sreu_top_test.sv
`timescale 1ns/10ps
`include "sreu_consts.svh"
module sreu_top_test;
  import sreu_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  sreu_wb_req_t wb_i  = '0;
  sreu_wb_rsp_t wb_o;
  logic         hold_i = 1'b0;
  logic         cts_i  = 1'b1;
  logic         rx_valid;
  logic [7:0]   rx_byte;
  logic         out_valid_o;
  sreu_out_t    out_o;
  logic         rts_o;
  logic         tx_ok_o;
  logic         tx_req_o;
  logic [7:0]   tx_char_o;
  logic         irq_o;
  int           errors   = 0;
  int           n_checks = 0;
  int           cycles   = 0;

  sreu_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .hold_i(hold_i),
    .cts_i(cts_i), .out_valid_o(out_valid_o), .out_o(out_o),
    .rts_o(rts_o), .tx_ok_o(tx_ok_o), .tx_req_o(tx_req_o),
    .tx_char_o(tx_char_o), .irq_o(irq_o));
  sreu_host_model host (.clk_i(clk_i), .rts_i(rts_o), .tx_req_i(tx_req_o),
    .tx_char_i(tx_char_o), .valid_o(rx_valid), .byte_o(rx_byte));

  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Cuts a hang short well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic results();
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: d};
    // Only the ack or the bench timeout ends this wait
    @(posedge clk_i);
    while (wb_o.ack !== 1'b1) begin
      @(posedge clk_i);
    end
    q = wb_o.dat;
    wb_i <= '0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask
  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, adr, 32'h0000_0000, q);
    check({8'h00, q}, {8'h00, exp});
  endtask
  task automatic mode(input logic [4:0] enc, input logic [1:0] flow);
    wr(`SREU_ADR_CTRL, {22'h0, flow, 3'h0, enc});
  endtask
  // Sends the low n bytes of s, most significant first
  task automatic send_str(input logic [63:0] s, input int n);
    int i;
    for (i = 0; i < n; i++) host.send(s[8*(n-1-i) +: 8], i % 2);
  endtask
  task automatic item(input logic [2:0] k, input logic [2:0] l,
                      input logic [31:0] d);
    sreu_out_t o;
    int        i;
    for (i = 0; i < 10; i++) begin
      #1;
      if (out_valid_o === 1'b1) break;
      @(posedge clk_i);
    end
    o = (i == 10) ? 'x : out_o;
    check({2'h0, o}, {2'h0, k, l, d});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rdc(`SREU_ADR_CTRL, 32'h0000_0000);
    rdc(`SREU_ADR_TRIG, `SREU_RST_TRIG);
    wr(`SREU_ADR_STATUS, 32'hFFFF_FFFF);
    rdc(`SREU_ADR_STATUS, 32'h0000_0000);
    rdc(8'h1C, 32'h0000_0000);
    check({39'h0, rts_o & tx_ok_o & ~irq_o}, 40'h1);
  endtask
  task automatic t_classes();
    logic [4:0] txt [3] = '{5'h01, 5'h04, 5'h06};
    logic [4:0] raw [6] = '{5'h02, 5'h05, 5'h07, 5'h08, 5'h09, 5'h0A};
    host.send(8'h0A, 0);
    item(KIND_ESC, 3'h3, 32'h005C_3041);
    host.send(8'h9F, 0);
    item(KIND_ESC, 3'h3, 32'h005C_3946);
    foreach (txt[j]) begin
      mode(txt[j], 2'h0);
      host.send(8'h07, 0);
      item(KIND_CMD, 3'h1, 32'h07);
      host.send(8'h20, 0);
      item(KIND_CHAR, 3'h1, 32'h20);
    end
    foreach (raw[j]) begin
      mode(raw[j], 2'h0);
      host.send(8'h03, 0);
      item(KIND_RAW, 3'h1, 32'h03);
      host.send(8'hFF, 0);
      item(KIND_RAW, 3'h1, 32'hFF);
    end
  endtask
  task automatic t_words();
    logic [4:0]  enc [9] = '{5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h03, 5'h0F,
                             5'h10, 5'h11, 5'h12};
    logic [63:0] s   [9] = '{64'h1234, 64'h1234, 64'h1234_5678,
      64'h1234_5678, 64'h4142_4344, 64'h4142_4364, 64'h4142_4344,
      64'h3132_3334_3536_3738, 64'h3132_3334_3536_3738};
    int          n   [9] = '{2, 2, 4, 4, 4, 4, 4, 8, 8};
    logic [2:0]  l   [9] = '{3'h2, 3'h2, 3'h4, 3'h4, 3'h2, 3'h2, 3'h2,
                             3'h4, 3'h4};
    logic [31:0] d   [9] = '{32'h1234, 32'h3412, 32'h1234_5678,
      32'h7856_3412, 32'hABCD, 32'hABCD, 32'hCDAB, 32'h1234_5678,
      32'h7856_3412};
    foreach (enc[j]) begin
      mode(enc[j], 2'h0);
      send_str(s[j], n[j]);
      item(KIND_WORD, l[j], d[j]);
    end
    mode(5'h10, 2'h0);
    wr(`SREU_ADR_CLEAR, 32'h7);
    send_str(64'h4147, 2);
    rdc(`SREU_ADR_STATUS, 32'h4);
    send_str(64'h3132_3334, 4);
    item(KIND_WORD, 3'h2, 32'h3412);
    mode(5'h03, 2'h0);
    send_str(64'h3132_6566, 4);
    item(KIND_WORD, 3'h2, 32'h12EF);
    rdc(`SREU_ADR_LAST, 32'h0000_12EF);
  endtask
  task automatic t_irq();
    mode(5'h0B, 2'h0);
    wr(`SREU_ADR_CLEAR, 32'h7);
    send_str(64'h5AA5, 2);
    rdc(`SREU_ADR_STATUS, 32'h1);
    check({39'h0, irq_o}, 40'h0);
    wr(`SREU_ADR_ENABLE, 32'h1);
    rdc(`SREU_ADR_ENABLE, 32'h1);
    check({39'h0, irq_o}, 40'h1);
    wr(`SREU_ADR_CLEAR, 32'h1);
    rdc(`SREU_ADR_STATUS, 32'h0);
    check({39'h0, irq_o}, 40'h0);
    host.send(8'hAA, 0);
    mode(5'h0C, 2'h0);
    send_str(64'h1234, 2);
    item(KIND_WORD, 3'h2, 32'h3412);
  endtask
  task automatic t_count();
    mode(5'h02, 2'h0);
    wr(`SREU_ADR_TRIG, 32'h3);
    wr(`SREU_ADR_CLEAR, 32'h7);
    send_str(64'h0102, 2);
    rdc(`SREU_ADR_STATUS, 32'h0);
    rdc(`SREU_ADR_RXCNT, 32'h2);
    host.send(8'h03, 0);
    rdc(`SREU_ADR_STATUS, 32'h2);
    rdc(`SREU_ADR_RXCNT, 32'h0);
    wr(`SREU_ADR_TRIG, 32'h0);
    wr(`SREU_ADR_CLEAR, 32'h7);
    send_str(64'h0102_0304, 4);
    rdc(`SREU_ADR_STATUS, 32'h0);
  endtask
  task automatic t_flow();
    mode(5'h02, 2'h2);
    @(posedge clk_i);
    hold_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check({31'h0, tx_req_o, tx_char_o}, {31'h1, `SREU_XOFF});
    @(posedge clk_i);
    hold_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check({31'h0, tx_req_o, tx_char_o}, {31'h1, `SREU_XON});
    host.send(`SREU_XOFF, 0);
    // Host flow state is registered, then tx_ok_o one edge later
    @(posedge clk_i);
    #1;
    check({39'h0, tx_ok_o}, 40'h0);
    host.send(`SREU_XON, 0);
    @(posedge clk_i);
    #1;
    check({39'h0, tx_ok_o}, 40'h1);
    mode(5'h02, 2'h1);
    @(posedge clk_i);
    hold_i <= 1'b1;
    cts_i  <= 1'b0;
    @(posedge clk_i);
    #1;
    check({38'h0, rts_o, tx_ok_o}, 40'h0);
    @(posedge clk_i);
    hold_i <= 1'b0;
    cts_i  <= 1'b1;
    @(posedge clk_i);
    #1;
    check({38'h0, rts_o, tx_ok_o}, 40'h3);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_classes();
    t_words();
    t_irq();
    t_count();
    t_flow();
    results();
  end
endmodule
